// File: pkg/adc_ctrl_pkg.sv
// Package: register map, field layout and types for the converter control sequencer
package adc_ctrl_pkg;

    // Byte offsets on the AXI4-Lite bus
    localparam logic [7:0] OFF_CTRL_FIRST   = 8'h00;
    localparam logic [7:0] OFF_SRC_CLK_SEL  = 8'h04;
    localparam logic [7:0] OFF_RESULT       = 8'h08;
    localparam logic [7:0] OFF_IRQ_STATUS   = 8'h0c;
    localparam logic [7:0] OFF_IRQ_MASK     = 8'h10;
    localparam logic [7:0] OFF_CORE_STATUS  = 8'h14;

    // First control register bit positions
    localparam int BIT_START      = 7;
    localparam int BIT_BUSY       = 6;
    localparam int BIT_ENABLE     = 5;
    localparam int BIT_ALIGN      = 4;

    // Reset values
    localparam logic [7:0] CTRL_FIRST_RST  = 8'h00;
    localparam logic [7:0] SRC_CLK_RST     = 8'h00;
    localparam logic [11:0] RESULT_RST     = 12'h000;

    // Sequence lengths in converter clock periods
    localparam logic [4:0] SAMPLE_PERIODS  = 5'h04;
    localparam logic [4:0] CONVERT_PERIODS = 5'h0c;

    // Input source codes
    localparam logic [2:0] SRC_AMP0 = 3'h1;
    localparam logic [2:0] SRC_AMP1 = 3'h2;
    localparam logic [2:0] SRC_AMP2 = 3'h3;
    localparam logic [2:0] SRC_DAC  = 3'h4;

    // Reference codes
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [1:0] REF_DAC    = 2'h2;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        IN_EXTERNAL    = 3'b001,
        IN_AMP_OUTPUT  = 3'b010,
        IN_DAC_OUTPUT  = 3'b100
    } input_class_e;

    // Analog routing toward the converter core
    typedef struct packed {
        logic       route_external;
        logic [3:0] external_channel;
        logic       amp_output_zero;
        logic       amp_output_one;
        logic       amp_output_two;
        logic       dac_output_source;
        logic       ref_external_pin;
        logic       ref_supply;
        logic       dac_reference_voltage;
        logic       core_power;
    } analog_route_s;

    // Sequencer handshake with the converter core
    typedef struct packed {
        logic core_reset;
        logic sample;
        logic convert_step;
    } core_ctrl_s;

endpackage

// File: logic/conv_clock_divider.sv
// Free-running divider emitting one enable pulse per converter clock period
`timescale 1ns/1ps
`default_nettype none
module conv_clock_divider
#(
    parameter int DIV_BITS = 3
)
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [DIV_BITS-1:0] divider_select,
    output logic                     tick
);
    localparam int CNT_W = (1 << DIV_BITS) - 1;

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] mask;

    if (DIV_BITS < 1 || DIV_BITS > 4)
    begin : g_param_check
        $error("conv_clock_divider: DIV_BITS out of range");
    end

    // Terminal count is 2**select - 1
    always_comb
    begin
        mask = CNT_W'((64'h1 << divider_select) - 64'h1);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            count_reg <= '0;
        else if ((count_reg & mask) == mask)
            count_reg <= '0;
        else
            count_reg <= count_reg + 1'b1;
    end

    // Select zero gives a tick every clock
    assign tick = ((count_reg & mask) == mask);

endmodule // conv_clock_divider
`default_nettype wire

// File: logic/adc_control_sequencer.sv
// Converter control sequencer with AXI4-Lite register slave
//
// Contract
// - Source code 000/101-111 routes external channel; 001-011 amplifiers; 100 DAC output.
// - Reference code 00/11 external pin, 01 supply, 10 DAC reference.
// - Converter clock is system clock divided by two to the select value.
// - Conversion starts only after start bit written high then low.
// - Busy flag reads one while converting, zero once finished.
// - Completion sets interrupt request flag; enabled flag drives interrupt output.
// - Converter circuitry powered only while enable bit is high.
// - Second control register is eight read/write bits resetting to zero.
// - Conversion lasts four sample plus twelve convert periods, then busy clears.
// - Start bit high resets converter logic; falling write begins conversion.
// - Alignment bit zero left-aligns result, one right-aligns; unused bits zero.
// - Result register pair is unchanged while converter disabled.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module adc_control_sequencer
#(
    parameter int RESULT_BITS = 12,
    parameter int DIV_BITS    = 3
)
(
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]                 s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [7:0]                 s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Converter core
    output adc_ctrl_pkg::analog_route_s     route,
    output adc_ctrl_pkg::core_ctrl_s        core_ctrl,
    input  wire logic [RESULT_BITS-1:0]     core_result,
    // Interrupt
    output logic                            irq
);
    import adc_ctrl_pkg::*;

    if (RESULT_BITS != 12 || DIV_BITS != 3)
    begin : g_param_check
        $error("adc_control_sequencer: logic serves 12 result bits and a three-bit divider only");
    end

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_SAMPLE  = 3'b010,
        ST_CONVERT = 3'b100
    } seq_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0]             ctrl_first_reg;
    logic [7:0]             src_clk_reg;
    logic [RESULT_BITS-1:0] result_reg;
    logic                   irq_status_reg;
    logic                   irq_mask_reg;
    seq_state_e             state_reg;
    logic [4:0]             period_reg;
    logic                   start_armed_reg;
    logic                   launch;
    logic                   done;
    logic                   tick;

    logic enable;
    logic start_bit;
    assign enable    = ctrl_first_reg[BIT_ENABLE];
    assign start_bit = ctrl_first_reg[BIT_START];

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path; address and data taken in either order
    logic       aw_held_reg;
    logic       w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic       wr_fire;
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held_reg <= 1'b0;
        end
    end

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == OFF_CTRL_FIRST) || (a == OFF_SRC_CLK_SEL) || (a == OFF_RESULT)
                  || (a == OFF_IRQ_STATUS) || (a == OFF_IRQ_MASK) || (a == OFF_CORE_STATUS);
    endfunction

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known_addr(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    logic wr_lane0;
    assign wr_lane0 = wr_fire && w_strb_reg[0];

    // Second control register, all bits read/write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            src_clk_reg <= SRC_CLK_RST;
        else if (wr_lane0 && aw_addr_reg == OFF_SRC_CLK_SEL)
            src_clk_reg <= w_data_reg[7:0];
    end

    // First control register; busy bit is read-only and not stored here
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_first_reg <= CTRL_FIRST_RST;
        else if (wr_lane0 && aw_addr_reg == OFF_CTRL_FIRST)
            ctrl_first_reg <= w_data_reg[7:0] & ~(8'h01 << BIT_BUSY);
    end

    // Arms for one cycle when a write lowers a start bit that stood high; a level never arms
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            start_armed_reg <= 1'b0;
        else
            start_armed_reg <= wr_lane0 && (aw_addr_reg == OFF_CTRL_FIRST) && start_bit && !w_data_reg[BIT_START];
    end
    assign launch = start_armed_reg && !start_bit && enable;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_mask_reg <= 1'b0;
        else if (wr_lane0 && aw_addr_reg == OFF_IRQ_MASK)
            irq_mask_reg <= w_data_reg[0];
    end

    // Sticky completion flag; a completion beats a same-cycle clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_status_reg <= 1'b0;
        else if (done)
            irq_status_reg <= 1'b1;
        else if (wr_lane0 && aw_addr_reg == OFF_IRQ_STATUS && w_data_reg[0])
            irq_status_reg <= 1'b0;
    end

    assign irq = irq_status_reg && irq_mask_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    logic [7:0] busy_byte;
    logic [7:0] res_high;
    logic [7:0] res_low;
    logic [31:0] rd_value;

    // Alignment packing, unused bits zero
    always_comb
    begin
        if (ctrl_first_reg[BIT_ALIGN])
        begin
            res_high = {4'h0, result_reg[11:8]};
            res_low  = result_reg[7:0];
        end
        else
        begin
            res_high = result_reg[11:4];
            res_low  = {result_reg[3:0], 4'h0};
        end
    end

    // Busy flag shows sequencer activity
    assign busy_byte = ctrl_first_reg | ((state_reg != ST_IDLE) ? (8'h01 << BIT_BUSY) : 8'h00);

    always_comb
    begin
        case (s_axi_araddr)
            OFF_CTRL_FIRST:  rd_value = {24'h000000, busy_byte};
            OFF_SRC_CLK_SEL: rd_value = {24'h000000, src_clk_reg};
            OFF_RESULT:      rd_value = {16'h0000, res_high, res_low};
            OFF_IRQ_STATUS:  rd_value = {31'h00000000, irq_status_reg};
            OFF_IRQ_MASK:    rd_value = {31'h00000000, irq_mask_reg};
            OFF_CORE_STATUS: rd_value = {29'h00000000, state_reg};
            default:         rd_value = 32'h0000_0000;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    conv_clock_divider #(
        .DIV_BITS       (DIV_BITS)
    ) u_div (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .divider_select (src_clk_reg[DIV_BITS-1:0]),
        .tick           (tick)
    );

    // Sixteen converter periods: four sample then twelve convert
    always_ff @(posedge aclk)
    begin
        if (!aresetn || start_bit || !enable)
        begin
            state_reg  <= ST_IDLE;
            period_reg <= 5'h00;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                    if (launch)
                    begin
                        state_reg  <= ST_SAMPLE;
                        period_reg <= 5'h00;
                    end
                ST_SAMPLE:
                    if (tick)
                    begin
                        if (period_reg == SAMPLE_PERIODS - 5'h01)
                        begin
                            state_reg  <= ST_CONVERT;
                            period_reg <= 5'h00;
                        end
                        else
                            period_reg <= period_reg + 5'h01;
                    end
                ST_CONVERT:
                    if (tick)
                    begin
                        if (period_reg == CONVERT_PERIODS - 5'h01)
                            state_reg <= ST_IDLE;
                        else
                            period_reg <= period_reg + 5'h01;
                    end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    assign done = (state_reg == ST_CONVERT) && tick && (period_reg == CONVERT_PERIODS - 5'h01)
               && !start_bit && enable;

    // Result captured only on completion, so disabling freezes it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            result_reg <= RESULT_RST;
        else if (done && enable)
            result_reg <= core_result;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Analog routing
    input_class_e in_class;
    logic [2:0]   src_sel;
    logic [1:0]   ref_sel;
    assign src_sel = src_clk_reg[7:5];
    assign ref_sel = src_clk_reg[4:3];

    always_comb
    begin
        case (src_sel)
            SRC_AMP0, SRC_AMP1, SRC_AMP2: in_class = IN_AMP_OUTPUT;
            SRC_DAC:                      in_class = IN_DAC_OUTPUT;
            default:                      in_class = IN_EXTERNAL;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            route     <= '0;
            core_ctrl <= '0;
        end
        else
        begin
            route.route_external        <= (in_class == IN_EXTERNAL);
            route.external_channel      <= ctrl_first_reg[3:0];
            route.amp_output_zero       <= (src_sel == SRC_AMP0);
            route.amp_output_one        <= (src_sel == SRC_AMP1);
            route.amp_output_two        <= (src_sel == SRC_AMP2);
            route.dac_output_source     <= (in_class == IN_DAC_OUTPUT);
            route.ref_supply            <= (ref_sel == REF_SUPPLY);
            route.dac_reference_voltage <= (ref_sel == REF_DAC);
            route.ref_external_pin      <= (ref_sel != REF_SUPPLY) && (ref_sel != REF_DAC);
            route.core_power            <= enable;
            core_ctrl.core_reset        <= start_bit;
            core_ctrl.sample            <= (state_reg == ST_SAMPLE);
            core_ctrl.convert_step      <= (state_reg == ST_CONVERT) && tick;
        end
    end

endmodule // adc_control_sequencer
`default_nettype wire

// File: tb/adc_seq_chk.sv
// Concurrent checks on the ports of the converter control sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_seq_chk
(
    input wire logic                        aclk,
    input wire logic                        aresetn,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic [31:0]                 s_axi_rdata,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready,
    input wire adc_ctrl_pkg::analog_route_s route,
    input wire adc_ctrl_pkg::core_ctrl_s    core_ctrl
);
    import adc_ctrl_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    a_source_onehot: assert property (
        aresetn && $past(aresetn) |-> $onehot({route.route_external, route.amp_output_zero,
        route.amp_output_one, route.amp_output_two, route.dac_output_source}))
        else $error("input routing not one-hot");
    a_ref_onehot: assert property (
        aresetn && $past(aresetn) |-> $onehot({route.ref_external_pin, route.ref_supply,
        route.dac_reference_voltage}))
        else $error("reference routing not one-hot");
    // Power may drop one cycle before the abort reaches sample
    a_power_sample: assert property (
        core_ctrl.sample |-> route.core_power || $past(route.core_power))
        else $error("sampling while unpowered");
    a_reset_quiet: assert property (
        core_ctrl.core_reset [*2] |-> !core_ctrl.sample && !core_ctrl.convert_step)
        else $error("activity while core held in reset");
    a_step_follows: assert property (
        $fell(core_ctrl.sample) && !core_ctrl.core_reset && route.core_power |-> ##[1:260] core_ctrl.convert_step)
        else $error("no conversion step after sampling");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
endmodule // adc_seq_chk

bind adc_control_sequencer adc_seq_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .route, .core_ctrl);
`default_nettype wire

// File: tb/conv_core_model.sv
// Behavioural analog converter core facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module conv_core_model
#(
    parameter logic [11:0] SAMPLE_VALUE = 12'hb5a
)
(
    input wire logic                        aclk,
    input wire adc_ctrl_pkg::analog_route_s route,
    input wire adc_ctrl_pkg::core_ctrl_s    core_ctrl,
    output logic [11:0]                     core_result
);
    import adc_ctrl_pkg::*;
    logic [11:0] churn_reg = 12'h5a5;
    ////////////////////////////////////////////////////////////////////////////////
    // Unpowered or reset core holds nothing stable, so the line keeps moving
    always_ff @(posedge aclk)
    begin
        churn_reg <= churn_reg + 12'h3c7;
    end
    assign core_result = (route.core_power && !core_ctrl.core_reset) ? SAMPLE_VALUE : churn_reg;
endmodule // conv_core_model
`default_nettype wire

// File: tb/adc_control_sequencer_bench.sv
// Self-checking bench for the converter control sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_control_sequencer_bench;
    import adc_ctrl_pkg::*;
    logic          aclk = 1'b0;
    logic          aresetn = 1'b0;
    logic [7:0]    s_axi_awaddr = 8'h00;
    logic [7:0]    s_axi_araddr = 8'h00;
    logic [31:0]   s_axi_wdata = 32'h0;
    logic [3:0]    s_axi_wstrb = 4'hf;
    logic          s_axi_awvalid = 1'b0;
    logic          s_axi_wvalid = 1'b0;
    logic          s_axi_bready = 1'b0;
    logic          s_axi_arvalid = 1'b0;
    logic          s_axi_rready = 1'b0;
    logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]    s_axi_bresp, s_axi_rresp;
    logic [31:0]   s_axi_rdata, d;
    analog_route_s route;
    core_ctrl_s    core_ctrl;
    logic [11:0]   core_result;
    int            miscompares = 0, samples_checked = 0, steps = 0, gap = 0, since = 0;

    adc_control_sequencer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .route,
        .core_ctrl, .core_result, .irq);
    conv_core_model core (.aclk, .route, .core_ctrl, .core_result);

    always #25 aclk = ~aclk;
    // Spacing of conversion steps, in system clocks
    always @(posedge aclk)
    begin
        since <= since + 1;
        if (core_ctrl.convert_step)
        begin
            steps <= steps + 1;
            gap <= since + 1;
            since <= 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic fail(input string what);
        miscompares++;
        $display("unexpected at %0t: %s", $time, what);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
            fail($sformatf("%s got %h expected %h", what, got, exp));
    endtask
    // Bus cycles sampled just after each edge, once that edge's updates have landed
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic aw_t, w_t, b_t;
        b_t = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_t)
        begin
            #1;
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid;
            if (b_t)
                check(32'(s_axi_bresp), 32'(er), "write response");
            @(posedge aclk);
            if (aw_t)
                s_axi_awvalid <= 1'b0;
            if (w_t)
                s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
        logic ar_t, r_t;
        r_t = 1'b0;
        v = 32'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_t)
        begin
            #1;
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t = s_axi_rvalid;
            v = s_axi_rdata;
            if (r_t)
                check(32'(s_axi_rresp), 32'(er), "read response");
            @(posedge aclk);
            if (ar_t)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_registers();
        rd(OFF_SRC_CLK_SEL, d, RESP_OKAY);
        check(d, 32'h0, "second control reset");
        wr(OFF_SRC_CLK_SEL, 32'hff, RESP_OKAY);
        rd(OFF_SRC_CLK_SEL, d, RESP_OKAY);
        check(d, 32'hff, "second control all bits");
        wr(OFF_CTRL_FIRST, 32'h40, RESP_OKAY);
        rd(OFF_CTRL_FIRST, d, RESP_OKAY);
        check(d, 32'h0, "busy not writable");
        wr(8'h20, 32'h1, RESP_SLVERR);
        rd(8'h20, d, RESP_SLVERR);
        check(d, 32'h0, "unmapped read");
    endtask
    task automatic t_routing();
        wr(OFF_CTRL_FIRST, 32'h0f, RESP_OKAY);
        @(negedge aclk);
        check(32'(route.external_channel), 32'hf, "parked external channel");
        for (int s = 0; s < 8; s++)
        begin
            wr(OFF_SRC_CLK_SEL, 32'(s) << 5, RESP_OKAY);
            repeat (2) @(negedge aclk);
            check({27'h0, route.route_external, route.amp_output_zero, route.amp_output_one, route.amp_output_two,
                route.dac_output_source}, (s == 0 || s > 4) ? 32'h10 : 32'h10 >> s, "source route");
        end
        for (int f = 0; f < 4; f++)
        begin
            wr(OFF_SRC_CLK_SEL, 32'(f) << 3, RESP_OKAY);
            repeat (2) @(negedge aclk);
            check({29'h0, route.ref_external_pin, route.ref_supply, route.dac_reference_voltage},
                (f == 1) ? 32'h2 : (f == 2) ? 32'h1 : 32'h4, "reference route");
        end
    endtask
    task automatic t_convert(input int sel, input logic al);
        int n;
        n = 0;
        wr(OFF_SRC_CLK_SEL, 32'(sel), RESP_OKAY);
        wr(OFF_CTRL_FIRST, 32'h20 | 32'(al) << 4, RESP_OKAY);
        repeat (40) @(negedge aclk);
        check(32'(route.core_power), 32'h1, "core powered");
        wr(OFF_CTRL_FIRST, 32'ha0 | 32'(al) << 4, RESP_OKAY);
        repeat (300) @(posedge aclk);
        rd(OFF_CTRL_FIRST, d, RESP_OKAY);
        check(32'(d[BIT_BUSY]), 32'h0, "start level alone");
        steps = 0;
        wr(OFF_CTRL_FIRST, 32'h20 | 32'(al) << 4, RESP_OKAY);
        rd(OFF_CTRL_FIRST, d, RESP_OKAY);
        check(32'(d[BIT_BUSY]), 32'h1, "busy after launch");
        rd(OFF_CORE_STATUS, d, RESP_OKAY);
        check(d, 32'h2, "sampling phase");
        d[BIT_BUSY] = 1'b1;
        while (d[BIT_BUSY] === 1'b1 && n < 1500)
        begin
            rd(OFF_CTRL_FIRST, d, RESP_OKAY);
            n++;
        end
        check(32'(d[BIT_BUSY]), 32'h0, "busy cleared");
        check(32'(steps), 32'd12, "conversion steps");
        check(32'(gap), 32'h1 << sel, "converter clock period");
        rd(OFF_RESULT, d, RESP_OKAY);
        check(d, al ? 32'h0b5a : 32'hb5a0, "result alignment");
        rd(OFF_IRQ_STATUS, d, RESP_OKAY);
        check(d, 32'h1, "completion flag");
    endtask
    task automatic t_interrupt();
        wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
        check(32'(irq), 32'h0, "masked interrupt");
        wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
        check(32'(irq), 32'h1, "unmasked interrupt");
        wr(OFF_IRQ_STATUS, 32'h1, RESP_OKAY);
        rd(OFF_IRQ_STATUS, d, RESP_OKAY);
        check(d, 32'h0, "flag cleared");
        check(32'(irq), 32'h0, "interrupt released");
    endtask
    task automatic t_disabled();
        wr(OFF_CTRL_FIRST, 32'h90, RESP_OKAY);
        wr(OFF_CTRL_FIRST, 32'h10, RESP_OKAY);
        repeat (2) @(negedge aclk);
        check(32'(route.core_power), 32'h0, "core unpowered");
        rd(OFF_CTRL_FIRST, d, RESP_OKAY);
        check(32'(d[BIT_BUSY]), 32'h0, "no launch while disabled");
        repeat (300) @(posedge aclk);
        rd(OFF_RESULT, d, RESP_OKAY);
        check(d, 32'h0b5a, "result kept while disabled");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #(50 * 40000);
        fail("watchdog expired");
        summarize();
    end
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_registers();
        t_routing();
        t_convert(4, 1'b0);
        t_interrupt();
        t_convert(7, 1'b1);
        t_disabled();
        summarize();
    end
endmodule // adc_control_sequencer_bench
`default_nettype wire
